// ==== inc/cesc_pkg.sv ====
// shared constants and types for the cpu execution state counter
package cesc_pkg;
    // ************************************************************
    // cycle weights in states
    // ************************************************************
    localparam logic [1:0] ST_FETCH_MEM = 2'h2;
    localparam logic [1:0] ST_BRANCH_MEM = 2'h2;
    localparam logic [1:0] ST_STACK_MEM = 2'h2;
    localparam logic [1:0] ST_BYTE_MEM = 2'h2;
    localparam logic [1:0] ST_WORD_MEM = 2'h2;
    localparam logic [1:0] ST_INTERNAL = 2'h1;
    localparam logic [1:0] ST_PERIPH_FAST = 2'h2;
    localparam logic [1:0] ST_PERIPH_SLOW = 2'h3;
    localparam int CNT_W = 4;
    localparam int SUM_W = 8;
    // ************************************************************
    // cycle counts per instruction class
    // ************************************************************
    localparam logic [3:0] N_FETCH_ONE = 4'h1;
    localparam logic [3:0] N_FETCH_TWO = 4'h2;
    localparam logic [3:0] N_FETCH_THREE = 4'h3;
    localparam logic [3:0] N_BYTE_READ = 4'h1;
    localparam logic [3:0] N_BYTE_RMW = 4'h2;
    localparam logic [3:0] N_BRANCH_WAIT = 4'h2;
    localparam logic [3:0] N_VECTOR_READ = 4'h1;
    localparam logic [3:0] N_STACK_PUSH = 4'h1;
    // ************************************************************
    // instruction classes
    // ************************************************************
    typedef enum logic [3:0] {
        CESC_REG_SIMPLE = 4'h0,
        CESC_IMM16 = 4'h1,
        CESC_IMM32 = 4'h3,
        CESC_AND_LONG_REG = 4'h2,
        CESC_BIT_MEM_RD = 4'h6,
        CESC_BIT_MEM_RMW = 4'h7,
        CESC_BRANCH_SHORT = 4'h5,
        CESC_BRANCH_LONG = 4'h4,
        CESC_SUBROUTINE_IND = 4'hc
    } cesc_class_t;
    typedef enum logic [1:0] {
        CESC_LOC_MEM = 2'h0,
        CESC_LOC_PERIPH_FAST = 2'h1,
        CESC_LOC_PERIPH_SLOW = 2'h3
    } cesc_loc_t;
endpackage

// ==== hdl/cesc_counter.sv ====
// execution state counter: cycle counts per instruction class, weighted sum
// Function
// [RULE1] total states is sum of six cycle counts times per-cycle states
// [RULE2] fetch from on-chip rom and byte access to on-chip ram take 2
// [RULE3] branch-address read from rom and stack cycle in ram take 2
// [RULE4] byte access to peripheral takes 2 or 3 states, by module
// [RULE5] per-class counts: 1, 2 or 3 fetches; bit memory, branches as listed
// [RULE6] a zero cycle count contributes no states
`timescale 1ns/1ps
module cesc_counter
    import cesc_pkg::*;
#(
    parameter int CNT_BITS = CNT_W,
    parameter int SUM_BITS = SUM_W
)
(
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic instr_valid,
    input wire cesc_class_t instr_class,
    input wire cesc_loc_t data_loc,
    output logic result_valid,
    output logic [CNT_BITS-1:0] cnt_fetch,
    output logic [CNT_BITS-1:0] cnt_branch,
    output logic [CNT_BITS-1:0] cnt_stack,
    output logic [CNT_BITS-1:0] cnt_byte,
    output logic [CNT_BITS-1:0] cnt_word,
    output logic [CNT_BITS-1:0] cnt_internal,
    output logic [SUM_BITS-1:0] exec_states
);
    // ************************************************************
    // parameter checks
    // ************************************************************
    // counts reach 3 and the largest total is 10; narrower fields would wrap without warning
    if (CNT_BITS < 2)
    begin : g_cnt_narrow
        $error("count width below 2 bits");
    end
    if (SUM_BITS < 4 || SUM_BITS < CNT_BITS)
    begin : g_sum_narrow
        $error("state total width too narrow");
    end

    // ************************************************************
    // helpers
    // ************************************************************
    // zero count yields zero regardless of weight
    function automatic logic [SUM_BITS-1:0] weigh(input logic [CNT_BITS-1:0] n, input logic [1:0] s);
        logic [SUM_BITS-1:0] r;
        r = '0;
        if (n != '0)  // RULE6
        begin
            r = SUM_BITS'(n) * SUM_BITS'(s);
        end
        return r;
    endfunction

    // ************************************************************
    // classification and sum
    // ************************************************************
    logic [CNT_BITS-1:0] next_fetch;
    logic [CNT_BITS-1:0] next_branch;
    logic [CNT_BITS-1:0] next_stack;
    logic [CNT_BITS-1:0] next_byte;
    // no decoded class has word accesses yet, so this count stays zero until one is added
    logic [CNT_BITS-1:0] next_word;
    logic [CNT_BITS-1:0] next_internal;
    logic [1:0] byte_weight;
    logic [SUM_BITS-1:0] next_states;
    logic next_valid;

    always_comb
    begin
        next_fetch = '0;
        next_branch = '0;
        next_stack = '0;
        next_byte = '0;
        next_word = '0;
        next_internal = '0;
        byte_weight = ST_BYTE_MEM;
        // an undecoded class costs one fetch, so a bad code never inflates the total
        case (instr_class)  // RULE5
            CESC_REG_SIMPLE: next_fetch = CNT_BITS'(N_FETCH_ONE);
            CESC_IMM16, CESC_AND_LONG_REG: next_fetch = CNT_BITS'(N_FETCH_TWO);
            CESC_IMM32: next_fetch = CNT_BITS'(N_FETCH_THREE);
            CESC_BIT_MEM_RD:
            begin
                next_fetch = CNT_BITS'(N_FETCH_TWO);
                next_byte = CNT_BITS'(N_BYTE_READ);
            end
            CESC_BIT_MEM_RMW:
            begin
                next_fetch = CNT_BITS'(N_FETCH_TWO);
                next_byte = CNT_BITS'(N_BYTE_RMW);
            end
            CESC_BRANCH_SHORT: next_fetch = CNT_BITS'(N_FETCH_TWO);
            CESC_BRANCH_LONG:
            begin
                next_fetch = CNT_BITS'(N_FETCH_TWO);
                next_internal = CNT_BITS'(N_BRANCH_WAIT);
            end
            CESC_SUBROUTINE_IND:
            begin
                next_fetch = CNT_BITS'(N_FETCH_TWO);
                next_branch = CNT_BITS'(N_VECTOR_READ);
                next_stack = CNT_BITS'(N_STACK_PUSH);
            end
            default: next_fetch = CNT_BITS'(N_FETCH_ONE);
        endcase
        // each peripheral has its own wait states, so the weight follows the addressed target
        case (data_loc)  // RULE4
            CESC_LOC_PERIPH_FAST: byte_weight = ST_PERIPH_FAST;
            CESC_LOC_PERIPH_SLOW: byte_weight = ST_PERIPH_SLOW;
            default: byte_weight = ST_BYTE_MEM;  // RULE2
        endcase
        next_states = weigh(next_fetch, ST_FETCH_MEM) + weigh(next_branch, ST_BRANCH_MEM)  // RULE1
            + weigh(next_stack, ST_STACK_MEM) + weigh(next_byte, byte_weight)  // RULE3
            + weigh(next_word, ST_WORD_MEM) + weigh(next_internal, ST_INTERNAL);  // RULE2
        next_valid = instr_valid;
        // reset wins over a valid instruction on the same edge
        if (sys_rst)
        begin
            next_fetch = '0;
            next_branch = '0;
            next_stack = '0;
            next_byte = '0;
            next_word = '0;
            next_internal = '0;
            next_states = '0;
            next_valid = 1'b0;
        end
    end

    // registers only: every next value, reset included, is settled above
    always_ff @(posedge core_clk)
    begin
        result_valid <= next_valid;
        exec_states <= next_states;
        cnt_fetch <= next_fetch;
        cnt_branch <= next_branch;
        cnt_stack <= next_stack;
        cnt_byte <= next_byte;
        cnt_word <= next_word;
        cnt_internal <= next_internal;
    end

    // ************************************************************
    // checks
    // ************************************************************
    property p_sum;
        @(posedge core_clk) disable iff (sys_rst)
        result_valid |-> exec_states == SUM_BITS'(32'(cnt_fetch) * ST_FETCH_MEM + 32'(cnt_branch) * ST_BRANCH_MEM
            + 32'(cnt_stack) * ST_STACK_MEM + 32'(cnt_word) * ST_WORD_MEM + 32'(cnt_internal) * ST_INTERNAL
            + 32'(cnt_byte) * (($past(data_loc) == CESC_LOC_PERIPH_SLOW) ? 32'(ST_PERIPH_SLOW)
            : ($past(data_loc) == CESC_LOC_PERIPH_FAST) ? 32'(ST_PERIPH_FAST) : 32'(ST_BYTE_MEM)));
    endproperty
    a_sum: assert property (p_sum) else $error("state sum wrong");  // RULE1

    // an edge that sees reset takes no instruction, so every antecedent below except that of a_rst excludes it
    property p_bit_rmw;
        @(posedge core_clk) disable iff (sys_rst)
        (!sys_rst && instr_valid && instr_class == CESC_BIT_MEM_RMW && data_loc == CESC_LOC_MEM)
            |=> exec_states == SUM_BITS'(8'h08);
    endproperty
    a_bit_rmw: assert property (p_bit_rmw) else $error("bit rmw in ram not 8 states");  // RULE2

    property p_sub_jump;
        @(posedge core_clk) disable iff (sys_rst)
        (!sys_rst && instr_valid && instr_class == CESC_SUBROUTINE_IND) |=> exec_states == SUM_BITS'(8'h08);
    endproperty
    a_sub_jump: assert property (p_sub_jump) else $error("indirect subroutine jump not 8 states");  // RULE3

    property p_slow;
        @(posedge core_clk) disable iff (sys_rst)
        (!sys_rst && instr_valid && instr_class == CESC_BIT_MEM_RD && data_loc == CESC_LOC_PERIPH_SLOW)
            |=> exec_states == SUM_BITS'(8'h07);
    endproperty
    a_slow: assert property (p_slow) else $error("slow peripheral byte access weight wrong");  // RULE4

    property p_fast;
        @(posedge core_clk) disable iff (sys_rst)
        (!sys_rst && instr_valid && instr_class == CESC_BIT_MEM_RMW && data_loc == CESC_LOC_PERIPH_FAST)
            |=> exec_states == SUM_BITS'(8'h08);
    endproperty
    a_fast: assert property (p_fast) else $error("fast peripheral byte access weight wrong");  // RULE4

    property p_imm32;
        @(posedge core_clk) disable iff (sys_rst)
        (!sys_rst && instr_valid && instr_class == CESC_IMM32)
            |=> cnt_fetch == CNT_BITS'(4'h3) && exec_states == SUM_BITS'(8'h06);
    endproperty
    a_imm32: assert property (p_imm32) else $error("32-bit immediate count wrong");  // RULE5

    property p_imm16;
        @(posedge core_clk) disable iff (sys_rst)
        (!sys_rst && instr_valid && (instr_class == CESC_IMM16 || instr_class == CESC_AND_LONG_REG))
            |=> cnt_fetch == CNT_BITS'(4'h2) && exec_states == SUM_BITS'(8'h04);
    endproperty
    a_imm16: assert property (p_imm16) else $error("two-fetch class count wrong");  // RULE5

    property p_bit_rd;
        @(posedge core_clk) disable iff (sys_rst)
        (!sys_rst && instr_valid && instr_class == CESC_BIT_MEM_RD && data_loc == CESC_LOC_MEM)
            |=> cnt_fetch == CNT_BITS'(4'h2) && cnt_byte == CNT_BITS'(4'h1) && exec_states == SUM_BITS'(8'h06);
    endproperty
    a_bit_rd: assert property (p_bit_rd) else $error("bit read in ram count wrong");  // RULE5

    property p_branch_long;
        @(posedge core_clk) disable iff (sys_rst)
        (!sys_rst && instr_valid && instr_class == CESC_BRANCH_LONG)
            |=> cnt_fetch == CNT_BITS'(4'h2) && cnt_internal == CNT_BITS'(4'h2) && exec_states == SUM_BITS'(8'h06);
    endproperty
    a_branch_long: assert property (p_branch_long) else $error("long branch count wrong");  // RULE5

    property p_zero;
        @(posedge core_clk) disable iff (sys_rst)
        (!sys_rst && instr_valid && instr_class == CESC_REG_SIMPLE)
            |=> exec_states == SUM_BITS'(8'h02) && cnt_byte == CNT_BITS'(4'h0);
    endproperty
    a_zero: assert property (p_zero) else $error("zero count contributed states");  // RULE6

    property p_valid;
        @(posedge core_clk) disable iff (sys_rst)
        (!sys_rst) |=> result_valid == $past(instr_valid);
    endproperty
    a_valid: assert property (p_valid) else $error("result valid does not follow instruction valid");  // RULE1

    // no disable here: this one watches reset itself
    property p_rst;
        @(posedge core_clk)
        sys_rst |=> !result_valid && exec_states == '0 && cnt_fetch == '0 && cnt_byte == '0 && cnt_internal == '0;
    endproperty
    a_rst: assert property (p_rst) else $error("outputs not cleared by reset");  // RULE1
endmodule

// ==== tb/cesc_periph_model.sv ====
// far-side model: picks where byte data cycles land
`timescale 1ns/1ps
module cesc_periph_model
    import cesc_pkg::*;
(
    input wire logic [1:0] loc_sel,
    output cesc_loc_t data_loc
);
    // ****
    // target decode
    // ****
    // wait states differ per module, so the choice is made per target
    always_comb
    begin
        case (loc_sel)
            2'h1: data_loc = CESC_LOC_PERIPH_FAST;
            2'h2: data_loc = CESC_LOC_PERIPH_SLOW;
            default: data_loc = CESC_LOC_MEM;
        endcase
    end
endmodule

// ==== tb/cesc_counter_tb.sv ====
// self-checking bench for the execution state counter
`timescale 1ns/1ps
module cesc_counter_tb;
    import cesc_pkg::*;
    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic instr_valid = 1'b0;
    cesc_class_t instr_class = CESC_REG_SIMPLE;
    logic [1:0] loc_sel = 2'h0;
    cesc_loc_t data_loc;
    logic result_valid;
    logic [CNT_W-1:0] cnt_fetch, cnt_branch, cnt_stack, cnt_byte, cnt_word, cnt_internal;
    logic [SUM_W-1:0] exec_states;
    int miscompares = 0;
    int check_count = 0;
    // ****
    // rows: class, target, then expected counts i j k l m n
    // ****
    // the last row holds a class code that nothing decodes; it must cost one fetch
    localparam int NROWS = 14;
    logic [31:0] rows [NROWS] = '{32'h00100000, 32'h02100000, 32'h10200000, 32'h20200000, 32'h30300000,
        32'h60200100, 32'h62200100, 32'h70200200, 32'h71200200, 32'h72200200, 32'h50200000,
        32'h40200002, 32'hc0211000, 32'h81100000};
    wire logic [35:0] got = {3'h0, result_valid, cnt_fetch, cnt_branch, cnt_stack, cnt_byte, cnt_word,
        cnt_internal, exec_states};
    always #2.5 core_clk = ~core_clk;
    cesc_periph_model i_cesc_periph_model (.loc_sel(loc_sel), .data_loc(data_loc));
    cesc_counter i_cesc_counter (.core_clk(core_clk), .sys_rst(sys_rst), .instr_valid(instr_valid),
        .instr_class(instr_class), .data_loc(data_loc), .result_valid(result_valid), .cnt_fetch(cnt_fetch),
        .cnt_branch(cnt_branch), .cnt_stack(cnt_stack), .cnt_byte(cnt_byte), .cnt_word(cnt_word),
        .cnt_internal(cnt_internal), .exec_states(exec_states));
    function automatic logic [SUM_W-1:0] exp_states(input logic [31:0] r);
        logic [1:0] w;
        w = (r[25:24] == 2'h2) ? ST_PERIPH_SLOW : (r[25:24] == 2'h1) ? ST_PERIPH_FAST : ST_BYTE_MEM;
        return r[23:20] * ST_FETCH_MEM + r[19:16] * ST_BRANCH_MEM + r[15:12] * ST_STACK_MEM
            + r[11:8] * w + r[7:4] * ST_WORD_MEM + r[3:0] * ST_INTERNAL;
    endfunction
    task automatic check(input logic [35:0] exp);
        check_count++;
        if (got !== exp)
        begin
            miscompares++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic results;
        if (miscompares == 0 && check_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial
    begin
        repeat (2) @(posedge core_clk);
        #1 check(36'h0);
        // back to back: each row is checked 1 ns after the edge that takes it
        for (int i = 0; i <= NROWS; i++)
        begin
            @(posedge core_clk);
            sys_rst <= 1'b0;
            instr_valid <= 1'b1;
            if (i < NROWS)
            begin
                instr_class <= cesc_class_t'(rows[i][31:28]);
                loc_sel <= rows[i][25:24];
            end
            #1 if (i > 0) check({4'h1, rows[i-1][23:0], exp_states(rows[i-1])});
        end
        @(posedge core_clk);
        instr_valid <= 1'b0;
        @(posedge core_clk);
        #1 check({4'h0, rows[NROWS-1][23:0], exp_states(rows[NROWS-1])});
        @(posedge core_clk);
        sys_rst <= 1'b1;
        instr_valid <= 1'b1;
        @(posedge core_clk);
        sys_rst <= 1'b0;
        instr_class <= cesc_class_t'(rows[4][31:28]);
        loc_sel <= rows[4][25:24];
        #1 check(36'h0);
        // mid-run release: the first instruction is taken on the very next edge
        @(posedge core_clk);
        #1 check({4'h1, rows[4][23:0], exp_states(rows[4])});
        results();
    end
    initial
    begin
        #2000;
        miscompares++;
        results();
    end
endmodule
